// *** src/ccr_cfg.svh ***
// Purpose: Constants for the comparator control register block
// Assumes: 16-bit registers, word index addressing on a plain port
// Notes:   Included by the package and the design
`ifndef CCR_CFG_SVH
`define CCR_CFG_SVH

// ----------------------------------------------------------------
// Register indices (port address)
// ----------------------------------------------------------------
`define CCR_ADDR_W            3
`define CCR_IDX_INPUT_SEL     3'h0
`define CCR_IDX_MODE_CTRL     3'h1
`define CCR_IDX_IRQ_STATUS    3'h2
`define CCR_IDX_IRQ_CLEAR     3'h3
`define CCR_IDX_IRQ_ENABLE    3'h4
`define CCR_IDX_LADDER_CFG    3'h5

// ----------------------------------------------------------------
// Field layout, input select register
// ----------------------------------------------------------------
`define CCR_NEG_EN_BIT        15
`define CCR_NEG_SEL_HI        11
`define CCR_NEG_SEL_LO        8
`define CCR_POS_EN_BIT        7
`define CCR_POS_SEL_HI        3
`define CCR_POS_SEL_LO        0
`define CCR_INSEL_WMASK       16'h8F8F

// ----------------------------------------------------------------
// Field layout, mode control register
// ----------------------------------------------------------------
`define CCR_MREF_EN_BIT       12
`define CCR_MREF_LVL_BIT      11
`define CCR_ON_BIT            10
`define CCR_PWR_HI            9
`define CCR_PWR_LO            8
`define CCR_FDLY_HI           7
`define CCR_FDLY_LO           6
`define CCR_EXCH_BIT          5
`define CCR_SHORT_BIT         4
`define CCR_EDGE_BIT          3
`define CCR_FILT_BIT          2
`define CCR_POL_BIT           1
`define CCR_OUT_BIT           0
`define CCR_MODE_WMASK        16'h1FFE

// ----------------------------------------------------------------
// Interrupt bits and ladder source
// ----------------------------------------------------------------
`define CCR_IRQ_W             2
`define CCR_IRQ_MAIN_BIT      0
`define CCR_IRQ_INV_BIT       1
`define CCR_LADDER_W          2
`define CCR_LADDER_OFF_CODE   2'h3

// ----------------------------------------------------------------
// Reset values and filter timing
// ----------------------------------------------------------------
`define CCR_REG_RESET         16'h0000
`define CCR_CLK_PERIOD_NS     10
`define CCR_FDLY0_NS          450
`define CCR_FDLY1_NS          900
`define CCR_FDLY2_NS          1800
`define CCR_FDLY3_NS          3600
`define CCR_FDLY_CNT_W        9

`endif

// *** src/ccr_pkg.sv ***
// Purpose: Types for the comparator control register block
// Assumes: ccr_cfg.svh defines the numeric constants
// Notes:   Types only
`include "ccr_cfg.svh"

package ccr_pkg;

  typedef enum logic [1:0] {
    CCR_PWR_HIGH_SPEED = 2'h0,
    CCR_PWR_NORMAL     = 2'h1,
    CCR_PWR_ULTRA_LOW  = 2'h2,
    CCR_PWR_RESERVED   = 2'h3
  } ccr_pwr_e;

  typedef enum logic [2:0] {
    CCR_FLT_IDLE   = 3'b001,
    CCR_FLT_COUNT  = 3'b010,
    CCR_FLT_SETTLE = 3'b100
  } ccr_flt_state_e;

  typedef logic [15:0] ccr_word_t;

endpackage

// *** src/ccr_top.sv ***
// Purpose: Control registers and output logic around an analog comparator
// Assumes: Inputs synchronous to CORE_CLK except the raw comparator output
// Notes:   Registers on a plain port, read data one cycle after the strobe
//
// Function
// - Negative channel routed to minus terminal only while its enable is one
// - Positive channel routed to plus terminal only while its enable is one
// - Reserved bits read zero and ignore writes
// - Manual enable zero: output picks tap; one: manual level picks tap unless the ladder code is three
// - Manual mode: level zero gives tap zero, one gives tap one
// - Comparator powered only while the on bit is one
// - Power field decodes high-speed, normal, ultra-low; code three reserved
// - Four filter delay steps 450, 900, 1800, 3600 ns
// - Exchange swaps the inputs and inverts the output
// - Input short closes the switch joining both terminals
// - Edge select chooses which edge sets main and inverted flags
// - Filter enable passes output through the delay filter
// - Polarity bit inverts the reported and used output
// - Output status bit is read-only, writes have no effect
// - Interrupt request only when module and global enables are set
// - Edge select change may set the flag, even when off
// - Automatic selection: tap one while output high, tap zero while low
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "ccr_cfg.svh"

module ccr_top
(
  input  wire logic                        CORE_CLK,
  input  wire logic                        SYS_RST,
  input  wire logic                        CLK_EN,
  input  wire logic [`CCR_ADDR_W-1:0]      REG_ADDR,
  input  wire logic [15:0]                 REG_WDATA,
  input  wire logic                        REG_WR,
  input  wire logic                        REG_RD,
  output logic      [15:0]                 REG_RDATA,
  input  wire logic                        COMP_RAW_OUT,
  input  wire logic                        GLOBAL_IRQ_ENABLE,
  output logic                             IRQ,
  output logic                             COMP_OUTPUT,
  output logic                             COMP_POWER_ON,
  output logic      [1:0]                  COMP_POWER_MODE,
  output logic                             NEG_CHANNEL_ENABLE,
  output logic      [3:0]                  NEG_CHANNEL_SELECT,
  output logic                             POS_CHANNEL_ENABLE,
  output logic      [3:0]                  POS_CHANNEL_SELECT,
  output logic                             INPUT_EXCHANGE,
  output logic                             INPUT_SHORT,
  output logic                             REF_TAP_ONE_SEL
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [`CCR_FDLY_CNT_W-1:0] delay_cycles(input logic [1:0] code);
    integer ns;
    begin
      case (code)
        2'h0:    ns = `CCR_FDLY0_NS;
        2'h1:    ns = `CCR_FDLY1_NS;
        2'h2:    ns = `CCR_FDLY2_NS;
        default: ns = `CCR_FDLY3_NS;
      endcase
      delay_cycles = `CCR_FDLY_CNT_W'(ns / `CCR_CLK_PERIOD_NS);
    end
  endfunction

  function automatic logic hit(input logic [`CCR_ADDR_W-1:0] a,
                               input logic [`CCR_ADDR_W-1:0] idx);
    hit = (a == idx);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ccr_pkg::ccr_word_t                in_sel_reg;
  ccr_pkg::ccr_word_t                mode_reg;
  logic [`CCR_IRQ_W-1:0]             irq_status_reg;
  logic [`CCR_IRQ_W-1:0]             irq_status_next;
  logic [`CCR_IRQ_W-1:0]             irq_enable_reg;
  logic [`CCR_LADDER_W-1:0]          ladder_reg;
  logic                              sync1_reg;
  logic                              sync2_reg;
  ccr_pkg::ccr_flt_state_e           flt_state_reg;
  logic [`CCR_FDLY_CNT_W-1:0]        flt_cnt_reg;
  logic                              flt_cand_reg;
  logic                              flt_out_reg;
  logic                              out_reg;
  logic                              out_prev_reg;
  logic                              edge_prev_reg;
  logic                              oriented;
  logic                              source;
  logic                              out_next;
  logic                              rise;
  logic                              fall;
  logic                              es_change;
  logic                              edge_sel;
  logic [15:0]                       rdata_next;

  assign edge_sel = mode_reg[`CCR_EDGE_BIT];

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Writes masked
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      in_sel_reg <= `CCR_REG_RESET;
      mode_reg   <= `CCR_REG_RESET;
      ladder_reg <= '0;
    end
    else if (CLK_EN && REG_WR)
    begin
      if (hit(REG_ADDR, `CCR_IDX_INPUT_SEL))
      begin
        in_sel_reg <= REG_WDATA & `CCR_INSEL_WMASK;
      end
      else if (hit(REG_ADDR, `CCR_IDX_MODE_CTRL))
      begin
        mode_reg <= REG_WDATA & `CCR_MODE_WMASK;
      end
      else if (hit(REG_ADDR, `CCR_IDX_LADDER_CFG))
      begin
        ladder_reg <= REG_WDATA[`CCR_LADDER_W-1:0];
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      irq_enable_reg <= '0;
    end
    else if (CLK_EN && REG_WR && hit(REG_ADDR, `CCR_IDX_IRQ_ENABLE))
    begin
      irq_enable_reg <= REG_WDATA[`CCR_IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Comparator output path
  // ----------------------------------------------------------------
  // Two-stage synchroniser
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end
    else if (CLK_EN)
    begin
      sync1_reg <= COMP_RAW_OUT;
      sync2_reg <= sync1_reg;
    end
  end

  assign oriented = sync2_reg ^ mode_reg[`CCR_EXCH_BIT];

  // Delay filter: a new level must hold for the selected delay
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      flt_state_reg <= ccr_pkg::CCR_FLT_IDLE;
      flt_cnt_reg   <= '0;
      flt_cand_reg  <= 1'b0;
      flt_out_reg   <= 1'b0;
    end
    else if (CLK_EN)
    begin
      case (flt_state_reg)
        ccr_pkg::CCR_FLT_IDLE:
        begin
          if (oriented != flt_out_reg)
          begin
            flt_cand_reg  <= oriented;
            flt_cnt_reg   <= delay_cycles(mode_reg[`CCR_FDLY_HI:`CCR_FDLY_LO]);
            flt_state_reg <= ccr_pkg::CCR_FLT_COUNT;
          end
        end
        ccr_pkg::CCR_FLT_COUNT:
        begin
          if (oriented != flt_cand_reg)
          begin
            flt_state_reg <= ccr_pkg::CCR_FLT_IDLE;
          end
          else if (flt_cnt_reg <= `CCR_FDLY_CNT_W'(1))
          begin
            flt_state_reg <= ccr_pkg::CCR_FLT_SETTLE;
          end
          else
          begin
            flt_cnt_reg <= flt_cnt_reg - `CCR_FDLY_CNT_W'(1);
          end
        end
        ccr_pkg::CCR_FLT_SETTLE:
        begin
          flt_out_reg   <= flt_cand_reg;
          flt_state_reg <= ccr_pkg::CCR_FLT_IDLE;
        end
        default:
        begin
          flt_state_reg <= ccr_pkg::CCR_FLT_IDLE;
        end
      endcase
    end
  end

  always_comb
  begin
    source = mode_reg[`CCR_FILT_BIT] ? flt_out_reg : oriented;
    if (!mode_reg[`CCR_ON_BIT])
    begin
      out_next = mode_reg[`CCR_POL_BIT];
    end
    else
    begin
      out_next = source ^ mode_reg[`CCR_POL_BIT];
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      out_reg       <= 1'b0;
      out_prev_reg  <= 1'b0;
      edge_prev_reg <= 1'b0;
    end
    else if (CLK_EN)
    begin
      out_reg       <= out_next;
      out_prev_reg  <= out_reg;
      edge_prev_reg <= edge_sel;
    end
  end

  // ----------------------------------------------------------------
  // Edge flags
  // ----------------------------------------------------------------
  assign rise      = out_reg && !out_prev_reg;
  assign fall      = !out_reg && out_prev_reg;
  assign es_change = edge_sel != edge_prev_reg;

  always_comb
  begin
    irq_status_next = irq_status_reg;
    if (REG_WR && hit(REG_ADDR, `CCR_IDX_IRQ_CLEAR))
    begin
      irq_status_next = irq_status_reg & ~REG_WDATA[`CCR_IRQ_W-1:0];
    end
    // Edge to flag mapping, set wins
    if ((edge_sel ? fall : rise) || es_change)
    begin
      irq_status_next[`CCR_IRQ_MAIN_BIT] = 1'b1;
    end
    if (edge_sel ? rise : fall)
    begin
      irq_status_next[`CCR_IRQ_INV_BIT] = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      irq_status_reg <= '0;
    end
    else if (CLK_EN)
    begin
      irq_status_reg <= irq_status_next;
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      IRQ <= 1'b0;
    end
    else if (CLK_EN)
    begin
      IRQ <= GLOBAL_IRQ_ENABLE && |(irq_status_next & irq_enable_reg);
    end
  end

  // ----------------------------------------------------------------
  // Analog control outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      COMP_OUTPUT        <= 1'b0;
      COMP_POWER_ON      <= 1'b0;
      COMP_POWER_MODE    <= ccr_pkg::CCR_PWR_HIGH_SPEED;
      NEG_CHANNEL_ENABLE <= 1'b0;
      NEG_CHANNEL_SELECT <= '0;
      POS_CHANNEL_ENABLE <= 1'b0;
      POS_CHANNEL_SELECT <= '0;
      INPUT_EXCHANGE     <= 1'b0;
      INPUT_SHORT        <= 1'b0;
      REF_TAP_ONE_SEL    <= 1'b0;
    end
    else if (CLK_EN)
    begin
      COMP_OUTPUT        <= out_next;
      COMP_POWER_ON      <= mode_reg[`CCR_ON_BIT];
      COMP_POWER_MODE    <= mode_reg[`CCR_PWR_HI:`CCR_PWR_LO];
      NEG_CHANNEL_ENABLE <= in_sel_reg[`CCR_NEG_EN_BIT];
      NEG_CHANNEL_SELECT <= in_sel_reg[`CCR_NEG_EN_BIT]
                            ? in_sel_reg[`CCR_NEG_SEL_HI:`CCR_NEG_SEL_LO] : 4'h0;
      POS_CHANNEL_ENABLE <= in_sel_reg[`CCR_POS_EN_BIT];
      POS_CHANNEL_SELECT <= in_sel_reg[`CCR_POS_EN_BIT]
                            ? in_sel_reg[`CCR_POS_SEL_HI:`CCR_POS_SEL_LO] : 4'h0;
      INPUT_EXCHANGE     <= mode_reg[`CCR_EXCH_BIT];
      INPUT_SHORT        <= mode_reg[`CCR_SHORT_BIT];
      if (mode_reg[`CCR_MREF_EN_BIT] && ladder_reg != `CCR_LADDER_OFF_CODE)
      begin
        REF_TAP_ONE_SEL <= mode_reg[`CCR_MREF_LVL_BIT];
      end
      else
      begin
        REF_TAP_ONE_SEL <= out_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata_next = 16'h0000;
    if (hit(REG_ADDR, `CCR_IDX_INPUT_SEL))
    begin
      rdata_next = in_sel_reg;
    end
    else if (hit(REG_ADDR, `CCR_IDX_MODE_CTRL))
    begin
      rdata_next = mode_reg;
      rdata_next[`CCR_OUT_BIT] = out_reg;
    end
    else if (hit(REG_ADDR, `CCR_IDX_IRQ_STATUS))
    begin
      rdata_next[`CCR_IRQ_W-1:0] = irq_status_reg;
    end
    else if (hit(REG_ADDR, `CCR_IDX_IRQ_ENABLE))
    begin
      rdata_next[`CCR_IRQ_W-1:0] = irq_enable_reg;
    end
    else if (hit(REG_ADDR, `CCR_IDX_LADDER_CFG))
    begin
      rdata_next[`CCR_LADDER_W-1:0] = ladder_reg;
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      REG_RDATA <= 16'h0000;
    end
    else if (CLK_EN)
    begin
      REG_RDATA <= REG_RD ? rdata_next : 16'h0000;
    end
  end

endmodule

`default_nettype wire

// *** test/ccr_top_checker.sv ***
// Purpose: Port-level checks for the comparator control block
// Assumes: One clock domain, reset SYS_RST
// Notes:   Bound to every ccr_top instance
`timescale 1ns/1ns
`default_nettype none
`include "ccr_cfg.svh"

module ccr_top_checker
(
  input wire logic                   CORE_CLK,
  input wire logic                   SYS_RST,
  input wire logic                   CLK_EN,
  input wire logic [`CCR_ADDR_W-1:0] REG_ADDR,
  input wire logic [15:0]            REG_WDATA,
  input wire logic                   REG_WR,
  input wire logic                   REG_RD,
  input wire logic [15:0]            REG_RDATA,
  input wire logic                   COMP_RAW_OUT,
  input wire logic                   GLOBAL_IRQ_ENABLE,
  input wire logic                   IRQ,
  input wire logic                   COMP_OUTPUT,
  input wire logic                   COMP_POWER_ON,
  input wire logic [1:0]             COMP_POWER_MODE,
  input wire logic                   NEG_CHANNEL_ENABLE,
  input wire logic [3:0]             NEG_CHANNEL_SELECT,
  input wire logic                   POS_CHANNEL_ENABLE,
  input wire logic [3:0]             POS_CHANNEL_SELECT,
  input wire logic                   INPUT_EXCHANGE,
  input wire logic                   INPUT_SHORT,
  input wire logic                   REF_TAP_ONE_SEL
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SYS_RST);

  // ----------------------------------------------------------------
  // Register strobes
  // ----------------------------------------------------------------
  sequence insel_wr;
    CLK_EN && REG_WR && REG_ADDR == `CCR_IDX_INPUT_SEL;
  endsequence
  sequence mode_wr;
    CLK_EN && REG_WR && REG_ADDR == `CCR_IDX_MODE_CTRL;
  endsequence

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  neg_gate_a: assert property (!NEG_CHANNEL_ENABLE |-> NEG_CHANNEL_SELECT == 4'h0)
    else $error("minus select not gated");
  pos_gate_a: assert property (!POS_CHANNEL_ENABLE |-> POS_CHANNEL_SELECT == 4'h0)
    else $error("plus select not gated");
  neg_follow_a: assert property (insel_wr |-> ##2 NEG_CHANNEL_ENABLE == $past(REG_WDATA[15], 2)
    && (!NEG_CHANNEL_ENABLE || NEG_CHANNEL_SELECT == $past(REG_WDATA[11:8], 2)))
    else $error("minus mux wrong after write");
  pos_follow_a: assert property (insel_wr |-> ##2 POS_CHANNEL_ENABLE == $past(REG_WDATA[7], 2)
    && (!POS_CHANNEL_ENABLE || POS_CHANNEL_SELECT == $past(REG_WDATA[3:0], 2)))
    else $error("plus mux wrong after write");
  power_follow_a: assert property (mode_wr |-> ##2 COMP_POWER_ON == $past(REG_WDATA[10], 2)
    && COMP_POWER_MODE == $past(REG_WDATA[9:8], 2))
    else $error("power outputs wrong after write");
  swap_follow_a: assert property (mode_wr |-> ##2 INPUT_EXCHANGE == $past(REG_WDATA[5], 2)
    && INPUT_SHORT == $past(REG_WDATA[4], 2))
    else $error("exchange or short wrong after write");
  rdata_idle_a: assert property ($past(CLK_EN) && !$past(REG_RD) |-> REG_RDATA == 16'h0000)
    else $error("read data not idle");
  insel_rsv_a: assert property ($past(REG_RD && REG_ADDR == `CCR_IDX_INPUT_SEL)
    |-> (REG_RDATA & ~`CCR_INSEL_WMASK) == 16'h0000)
    else $error("input select reserved bits set");
  mode_read_a: assert property ($past(REG_RD && REG_ADDR == `CCR_IDX_MODE_CTRL)
    |-> REG_RDATA[15:13] == 3'h0 && REG_RDATA[0] == $past(COMP_OUTPUT))
    else $error("mode read reserved or status bit wrong");
  irq_gate_a: assert property (IRQ |-> $past(GLOBAL_IRQ_ENABLE))
    else $error("interrupt without global enable");
endmodule

bind ccr_top ccr_top_checker chk_u
(
  .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .COMP_RAW_OUT(COMP_RAW_OUT), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .IRQ(IRQ),
  .COMP_OUTPUT(COMP_OUTPUT), .COMP_POWER_ON(COMP_POWER_ON), .COMP_POWER_MODE(COMP_POWER_MODE),
  .NEG_CHANNEL_ENABLE(NEG_CHANNEL_ENABLE), .NEG_CHANNEL_SELECT(NEG_CHANNEL_SELECT),
  .POS_CHANNEL_ENABLE(POS_CHANNEL_ENABLE), .POS_CHANNEL_SELECT(POS_CHANNEL_SELECT),
  .INPUT_EXCHANGE(INPUT_EXCHANGE), .INPUT_SHORT(INPUT_SHORT), .REF_TAP_ONE_SEL(REF_TAP_ONE_SEL)
);
`default_nettype wire

// *** test/ccr_top_tb.sv ***
// Purpose: Self-checking bench for the comparator control block
// Assumes: CLK_EN high except in the freeze case
// Notes:   Random register words from a fixed seed plus corner cases
`timescale 1ns/1ns
`default_nettype none
`include "ccr_cfg.svh"

module ccr_top_tb;
  logic                   clk = 1'h0;
  logic                   rst = 1'h1;
  logic [`CCR_ADDR_W-1:0] addr = '0;
  logic [15:0]            wdata = 16'h0000;
  logic                   wr = 1'h0;
  logic                   rd = 1'h0;
  logic                   raw = 1'h0;
  logic                   global_irq_enable = 1'h0;
  logic                   cen = 1'h1;
  logic [15:0]            rdata;
  logic                   irq, cout, pon, nen, pen, xch, sht, tap;
  logic [1:0]             pmode;
  logic [3:0]             nsel, psel;
  logic [15:0]            d, v;
  int                     bad_count = 0;
  int                     samples_checked = 0;
  int                     k, n;

  always #5 clk = ~clk;

  ccr_top dut_u
  (
    .CORE_CLK(clk), .SYS_RST(rst), .CLK_EN(cen), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .COMP_RAW_OUT(raw),
    .GLOBAL_IRQ_ENABLE(global_irq_enable), .IRQ(irq), .COMP_OUTPUT(cout), .COMP_POWER_ON(pon),
    .COMP_POWER_MODE(pmode), .NEG_CHANNEL_ENABLE(nen), .NEG_CHANNEL_SELECT(nsel),
    .POS_CHANNEL_ENABLE(pen), .POS_CHANNEL_SELECT(psel), .INPUT_EXCHANGE(xch),
    .INPUT_SHORT(sht), .REF_TAP_ONE_SEL(tap)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic out_exp(input logic r, input logic x, input logic p, input logic on);
    return on ? (r ^ x ^ p) : p;
  endfunction

  task automatic test_done();
    if (bad_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr_reg(input logic [`CCR_ADDR_W-1:0] a, input logic [15:0] dd);
    @(posedge clk);
    addr <= a;
    wdata <= dd;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask

  task automatic rd_reg(input logic [`CCR_ADDR_W-1:0] a, output logic [15:0] dd);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 dd = rdata;
  endtask

  task automatic wt(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  initial
  begin
    #500000;
    bad_count++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(89256));
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    for (k = 0; k < 8; k++)
    begin
      rd_reg(k[2:0], v);
      chk("reset", 16'h0000, v);
    end
    for (k = 0; k < 12; k++)
    begin
      d = (k == 0) ? 16'hFFFF : (k == 1) ? 16'h7F7F : 16'($urandom);
      wr_reg(`CCR_IDX_INPUT_SEL, d);
      rd_reg(`CCR_IDX_INPUT_SEL, v);
      chk("insel", d & 16'h8F8F, v);
      chk("neg", {11'h0, d[15], d[15] ? d[11:8] : 4'h0}, {11'h0, nen, nsel});
      chk("pos", {11'h0, d[7], d[7] ? d[3:0] : 4'h0}, {11'h0, pen, psel});
    end
    // Clock enable low: a write is ignored and outputs hold
    @(posedge clk) cen <= 1'h0;
    wr_reg(`CCR_IDX_INPUT_SEL, ~d);
    @(posedge clk) cen <= 1'h1;
    rd_reg(`CCR_IDX_INPUT_SEL, v);
    chk("frozen", d & 16'h8F8F, v);
    chk("frozenneg", {11'h0, d[15], d[15] ? d[11:8] : 4'h0}, {11'h0, nen, nsel});
    for (k = 0; k < 12; k++)
    begin
      d = (k == 0) ? 16'hFBFF : 16'($urandom) & 16'hFBFF;
      d[8] = d[8] & ~d[9];
      wr_reg(`CCR_IDX_MODE_CTRL, d);
      wt(4);
      rd_reg(`CCR_IDX_MODE_CTRL, v);
      chk("mode", (d & 16'h1FFE) | {15'h0, d[1]}, v);
      chk("power", {13'h0, 1'h0, d[9:8]}, {13'h0, pon, pmode});
      chk("swap", {14'h0, d[5], d[4]}, {14'h0, xch, sht});
      chk("offout", {15'h0, d[1]}, {15'h0, cout});
    end
    for (k = 6; k < 8; k++)
    begin
      wr_reg(k[2:0], 16'hFFFF);
      rd_reg(k[2:0], v);
      chk("unmapped", 16'h0000, v);
    end
    for (k = 0; k < 8; k++)
    begin
      wr_reg(`CCR_IDX_MODE_CTRL, 16'h0400 | {10'h0, k[1], 3'h0, k[0], 1'h0});
      @(posedge clk) raw <= k[2];
      wt(8);
      chk("out", {15'h0, out_exp(k[2], k[1], k[0], 1'h1)}, {15'h0, cout});
      chk("autotap", {15'h0, out_exp(k[2], k[1], k[0], 1'h1)}, {15'h0, tap});
      chk("pon", 16'h0001, {15'h0, pon});
    end
    @(posedge clk) raw <= 1'h0;
    for (k = 0; k < 4; k++)
    begin
      n = `CCR_FDLY0_NS / `CCR_CLK_PERIOD_NS << k;
      wr_reg(`CCR_IDX_MODE_CTRL, 16'h0404 | 16'(k << 6));
      wt(n + 10);
      @(posedge clk) raw <= 1'h1;
      wt(n / 2);
      @(posedge clk) raw <= 1'h0;
      wt(n + 10);
      chk("glitch", 16'h0000, {15'h0, cout});
      @(posedge clk) raw <= 1'h1;
      wt(n - 10);
      chk("early", 16'h0000, {15'h0, cout});
      wt(20);
      chk("late", 16'h0001, {15'h0, cout});
      @(posedge clk) raw <= 1'h0;
    end
    wr_reg(`CCR_IDX_MODE_CTRL, 16'h0400);
    @(posedge clk) raw <= 1'h1;
    wt(8);
    chk("tap", 16'h0001, {15'h0, tap});
    wr_reg(`CCR_IDX_MODE_CTRL, 16'h1400);
    wt(4);
    chk("tap", 16'h0000, {15'h0, tap});
    @(posedge clk) raw <= 1'h0;
    wr_reg(`CCR_IDX_MODE_CTRL, 16'h1C00);
    wt(8);
    chk("tap", 16'h0001, {15'h0, tap});
    wr_reg(`CCR_IDX_LADDER_CFG, 16'h0003);
    wt(4);
    chk("tap", 16'h0000, {15'h0, tap});
    wr_reg(`CCR_IDX_LADDER_CFG, 16'h0000);
    wr_reg(`CCR_IDX_IRQ_ENABLE, 16'h0003);
    global_irq_enable <= 1'h1;
    wr_reg(`CCR_IDX_MODE_CTRL, 16'h0400);
    wt(6);
    wr_reg(`CCR_IDX_IRQ_CLEAR, 16'h0003);
    @(posedge clk) raw <= 1'h1;
    wt(8);
    rd_reg(`CCR_IDX_IRQ_STATUS, v);
    chk("rise", 16'h0001, v);
    chk("irq", 16'h0001, {15'h0, irq});
    @(posedge clk) global_irq_enable <= 1'h0;
    wt(3);
    chk("irq", 16'h0000, {15'h0, irq});
    @(posedge clk) global_irq_enable <= 1'h1;
    wr_reg(`CCR_IDX_IRQ_CLEAR, 16'h0003);
    @(posedge clk) raw <= 1'h0;
    wt(8);
    rd_reg(`CCR_IDX_IRQ_STATUS, v);
    chk("fall", 16'h0002, v);
    wr_reg(`CCR_IDX_IRQ_CLEAR, 16'h0003);
    wr_reg(`CCR_IDX_MODE_CTRL, 16'h0408);
    wt(3);
    rd_reg(`CCR_IDX_IRQ_STATUS, v);
    chk("edgechg", 16'h0001, v);
    wr_reg(`CCR_IDX_IRQ_CLEAR, 16'h0003);
    @(posedge clk) raw <= 1'h1;
    wt(8);
    rd_reg(`CCR_IDX_IRQ_STATUS, v);
    chk("rise1", 16'h0002, v);
    @(posedge clk) raw <= 1'h0;
    wt(8);
    rd_reg(`CCR_IDX_IRQ_STATUS, v);
    chk("fall1", 16'h0003, v);
    wr_reg(`CCR_IDX_IRQ_ENABLE, 16'h0000);
    wt(3);
    chk("masked", 16'h0000, {15'h0, irq});
    wr_reg(`CCR_IDX_IRQ_CLEAR, 16'h0003);
    rd_reg(`CCR_IDX_IRQ_STATUS, v);
    chk("cleared", 16'h0000, v);
    test_done();
  end
endmodule
`default_nettype wire
